// File: rtl/mioad_defines.svh
// Purpose: Shared constants for the memory and I/O address decoder.
// Assumes: CPU bus runs on clk_sys; 16-bit logical address seen by the decoder.
// Notes:   Access times are in nanoseconds; wait counts are CPU wait states.
`ifndef MIOAD_DEFINES_SVH
`define MIOAD_DEFINES_SVH

`define MIOAD_A15_BIT          15
`define MIOAD_IO_GRP_HI        7
`define MIOAD_IO_GRP_LO        6
`define MIOAD_IO_GRP_ONCHIP    2'h0
`define MIOAD_IO_GRP_SERIAL    2'h3
`define MIOAD_ONCHIP_IO_TOP    8'h3F

`define MIOAD_EPROM_FAST_NS    9'h0AA
`define MIOAD_EPROM_SLOW_NS    9'h0C8
`define MIOAD_SRAM_SLOW_NS     9'h096
`define MIOAD_SRAM_FAST_NS     9'h055

`define MIOAD_WS_EPROM_FAST    2'h1
`define MIOAD_WS_EPROM_SLOW    2'h2
`define MIOAD_WS_SRAM_SLOW     2'h1
`define MIOAD_WS_SRAM_FAST     2'h0
`define MIOAD_WS_IO_DEFAULT    2'h1

`endif

// File: rtl/mioad_pkg.sv
// Purpose: Types for the memory and I/O address decoder.
// Assumes: Constants live in mioad_defines.svh.
// Notes:   The bus struct groups the CPU strobes that travel together.
package mioad_pkg;

	typedef struct packed {
		logic [15:0] addr;
		logic        memory_request_n_n;
		logic        io_request_n_n;
		logic        rd_n;
		logic        wr_n;
		logic        m1_n;
	} mioad_bus_t;

	typedef enum logic {
		MIOAD_WS_IDLE  = 1'b0,
		MIOAD_WS_COUNT = 1'b1
	} mioad_ws_state_t;

endpackage

// File: rtl/mioad_decoder.sv
// Purpose: Chip selects, strobes and wait-state control for an EPROM, an SRAM and a
//          serial controller hung off a CPU bus.
// Assumes: The CPU bus is synchronous to clk_sys, so its signals need no synchroniser.
// Notes:   Selects and strobes are combinational on purpose; only the wait counter and its state,
//          the wait request and the cycle-start history are registered.
`timescale 1ns/10ps
`include "mioad_defines.svh"
`default_nettype none

module mioad_decoder
	import mioad_pkg::*;
#(
	parameter logic [1:0] IO_WAITS = `MIOAD_WS_IO_DEFAULT
) (
	input  wire  logic       clk_sys,
	input  wire  logic       reset,
	input  wire  mioad_bus_t bus,
	input  wire  logic       user_ram_select,
	input  wire  logic       user_rom_select,
	input  wire  logic       user_io_enable,
	input  wire  logic       sram_remap,
	input  wire  logic       fetch_marker_enable_bit,
	input  wire  logic       io_cycle_timing_select,
	input  wire  logic [8:0] eprom_access_ns,
	input  wire  logic [8:0] sram_access_ns,
	output var   logic       rom_chip_select_n,
	output var   logic       ram_chip_select_n,
	output var   logic       mem_output_enable_n,
	output var   logic       sram_write_enable_n,
	output var   logic       peripheral_read_strobe_n,
	output var   logic       peripheral_write_strobe_n,
	output var   logic       serial_ctrl_chip_enable,
	output var   logic [1:0] serial_reg_select,
	output var   logic       fetch_marker_out_n,
	output var   logic       cpu_wait_n
);

	// The I/O page group lives in address bits 7:6.
	function automatic logic [1:0] io_group(input logic [15:0] a);
		io_group = a[`MIOAD_IO_GRP_HI:`MIOAD_IO_GRP_LO];
	endfunction

	// Wait states a memory access needs for the part behind the selected region.
	function automatic logic [1:0] mem_waits(input logic is_rom,
		input logic [8:0] rom_ns, input logic [8:0] ram_ns);
		if (is_rom) begin
			if (rom_ns <= `MIOAD_EPROM_FAST_NS)
				mem_waits = `MIOAD_WS_EPROM_FAST;
			else
				mem_waits = `MIOAD_WS_EPROM_SLOW;
		end else begin
			if (ram_ns <= `MIOAD_SRAM_FAST_NS)
				mem_waits = `MIOAD_WS_SRAM_FAST;
			else
				mem_waits = `MIOAD_WS_SRAM_SLOW;
		end
	endfunction

	logic            low_half;
	logic            rom_hit;
	logic            ram_hit;
	logic            mem_start;
	logic            io_start;
	logic            fetch_cycle;
	logic            waits_wanted;
	logic [1:0]      load_count;
	logic            memory_request_n_prev_r;
	logic            memory_request_n_prev_nxt;
	logic            io_request_n_prev_r;
	logic            io_request_n_prev_nxt;
	logic [1:0]      count_r;
	logic [1:0]      count_nxt;
	mioad_ws_state_t ws_r;
	mioad_ws_state_t ws_nxt;
	logic            wait_n_r;
	logic            wait_n_nxt;

	// Memory decode. Only A15 is looked at, so each device spans 32K bytes unless sram_remap gives the SRAM both halves.
	always_comb begin
		low_half = ~bus.addr[`MIOAD_A15_BIT];
		// After the image copy the SRAM shadows the EPROM half as well.
		rom_hit = low_half & user_rom_select & ~sram_remap;
		ram_hit = (~low_half | sram_remap) & user_ram_select;
		// Gating with I/O request keeps I/O and acknowledge cycles off memory.
		rom_chip_select_n = ~(rom_hit & bus.io_request_n_n);
		ram_chip_select_n = ~(ram_hit & bus.io_request_n_n);
		mem_output_enable_n = bus.rd_n;
		sram_write_enable_n = bus.wr_n;
	end

	// I/O decode and strobes.
	always_comb begin
		// Address and user_io_enable only, so the select is settled before either strobe falls.
		serial_ctrl_chip_enable = (io_group(bus.addr) == `MIOAD_IO_GRP_SERIAL)
			& user_io_enable;
		serial_reg_select = bus.addr[1:0];
		// With the late form selected, read waits one clock after I/O request.
		peripheral_read_strobe_n = bus.io_request_n_n | bus.rd_n
			| (io_cycle_timing_select & io_request_n_prev_r);
		peripheral_write_strobe_n = bus.io_request_n_n | bus.wr_n;
		// Return-from-interrupt is not visible on the bus, so only the acknowledge
		// half of the cleared-bit case is marked.
		if (fetch_marker_enable_bit)
			fetch_marker_out_n = bus.m1_n | bus.memory_request_n_n;
		else
			fetch_marker_out_n = bus.m1_n | bus.io_request_n_n;
	end

	// Wait-state generator.
	always_comb begin
		memory_request_n_prev_nxt = bus.memory_request_n_n;
		io_request_n_prev_nxt = bus.io_request_n_n;
		mem_start = ~bus.memory_request_n_n & memory_request_n_prev_r;
		io_start = ~bus.io_request_n_n & io_request_n_prev_r & bus.m1_n;
		fetch_cycle = ~bus.m1_n;
		// With the marker enabled, memory waits go to opcode fetches only.
		waits_wanted = ~fetch_marker_enable_bit | fetch_cycle;
		load_count = 2'h0;
		if (mem_start & (rom_hit | ram_hit) & waits_wanted)
			load_count = mem_waits(rom_hit, eprom_access_ns, sram_access_ns);
		else if (io_start)
			load_count = IO_WAITS;
		ws_nxt = ws_r;
		count_nxt = count_r;
		case (ws_r)
			MIOAD_WS_IDLE: begin
				if (load_count != 2'h0) begin
					count_nxt = load_count;
					ws_nxt = MIOAD_WS_COUNT;
				end
			end
			MIOAD_WS_COUNT: begin
				count_nxt = count_r - 2'h1;
				if (count_r == 2'h1)
					ws_nxt = MIOAD_WS_IDLE;
			end
			default: begin
				count_nxt = 2'h0;
				ws_nxt = MIOAD_WS_IDLE;
			end
		endcase
		wait_n_nxt = (count_nxt == 2'h0);
		cpu_wait_n = wait_n_r;
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			memory_request_n_prev_r <= 1'b1;
			io_request_n_prev_r <= 1'b1;
			count_r <= 2'h0;
			ws_r <= MIOAD_WS_IDLE;
			wait_n_r <= 1'b1;
		end else begin
			memory_request_n_prev_r <= memory_request_n_prev_nxt;
			io_request_n_prev_r <= io_request_n_prev_nxt;
			count_r <= count_nxt;
			ws_r <= ws_nxt;
			wait_n_r <= wait_n_nxt;
		end
	end

	// Helper terms read only by the checks below.
	logic chk_rom_start;
	logic chk_ram_start;
	assign chk_rom_start = mem_start & rom_hit & waits_wanted & ws_r == MIOAD_WS_IDLE;
	assign chk_ram_start = mem_start & ram_hit & waits_wanted & ws_r == MIOAD_WS_IDLE;

	chk_io_no_mem: assert property (@(posedge clk_sys) disable iff (reset)
		!bus.io_request_n_n |-> rom_chip_select_n && ram_chip_select_n)
		else $error("Memory selected during an I/O cycle.");

	chk_strobe_pass: assert property (@(posedge clk_sys) disable iff (reset)
		mem_output_enable_n == bus.rd_n && sram_write_enable_n == bus.wr_n)
		else $error("Memory strobes do not follow the CPU strobes.");

	chk_rom_region: assert property (@(posedge clk_sys) disable iff (reset)
		(bus.io_request_n_n && !bus.addr[15] && user_rom_select && !sram_remap)
		|-> !rom_chip_select_n && ram_chip_select_n)
		else $error("Low half does not select only the EPROM.");

	chk_ram_region: assert property (@(posedge clk_sys) disable iff (reset)
		(bus.io_request_n_n && bus.addr[15] && user_ram_select) |-> !ram_chip_select_n
		&& rom_chip_select_n)
		else $error("High half does not select only the SRAM.");

	chk_eprom_one_wait: assert property (@(posedge clk_sys) disable iff (reset)
		chk_rom_start && eprom_access_ns <= 9'h0AA |=> !cpu_wait_n ##1 cpu_wait_n)
		else $error("Fast EPROM did not get exactly one wait state.");

	chk_eprom_two_wait: assert property (@(posedge clk_sys) disable iff (reset)
		chk_rom_start && eprom_access_ns == 9'h0C8 |=> !cpu_wait_n [*2] ##1 cpu_wait_n)
		else $error("200 ns EPROM did not get exactly two wait states.");

	chk_sram_one_wait: assert property (@(posedge clk_sys) disable iff (reset)
		chk_ram_start && sram_access_ns == 9'h096 |=> !cpu_wait_n ##1 cpu_wait_n)
		else $error("150 ns SRAM did not get exactly one wait state.");

	chk_sram_no_wait: assert property (@(posedge clk_sys) disable iff (reset)
		chk_ram_start && sram_access_ns <= 9'h055 |=> cpu_wait_n [*2])
		else $error("Fast SRAM was given a wait state.");

	chk_marker_mode: assert property (@(posedge clk_sys) disable iff (reset)
		!fetch_marker_out_n |-> !bus.m1_n
		&& (fetch_marker_enable_bit ? !bus.memory_request_n_n : !bus.io_request_n_n))
		else $error("Marker active in the wrong kind of cycle.");

	chk_io_strobes: assert property (@(posedge clk_sys) disable iff (reset)
		(!peripheral_read_strobe_n || !peripheral_write_strobe_n) |-> !bus.io_request_n_n)
		else $error("Peripheral strobe without I/O request.");

	chk_classic_read: assert property (@(posedge clk_sys) disable iff (reset)
		!io_cycle_timing_select && !bus.io_request_n_n && !bus.rd_n
		|-> !peripheral_read_strobe_n)
		else $error("Classic I/O read strobe missing.");

	chk_onchip_free: assert property (@(posedge clk_sys) disable iff (reset)
		bus.addr[7:0] <= 8'h3F |-> !serial_ctrl_chip_enable)
		else $error("Off-chip select inside the on-chip I/O space.");

	chk_serial_image: assert property (@(posedge clk_sys) disable iff (reset)
		(bus.addr[7:6] == 2'h3 && user_io_enable) == serial_ctrl_chip_enable)
		else $error("Serial controller select outside its image range.");

	chk_io_wait: assert property (@(posedge clk_sys) disable iff (reset)
		io_start && ws_r == MIOAD_WS_IDLE && IO_WAITS == 2'h1
		|=> !cpu_wait_n ##1 cpu_wait_n)
		else $error("I/O cycle wait count wrong.");

	chk_io_two_wait: assert property (@(posedge clk_sys) disable iff (reset)
		io_start && bus.memory_request_n_n && ws_r == MIOAD_WS_IDLE && IO_WAITS == 2'h2
		|=> !cpu_wait_n [*2] ##1 cpu_wait_n)
		else $error("I/O cycle did not get exactly two wait states.");

	chk_late_read: assert property (@(posedge clk_sys) disable iff (reset)
		io_cycle_timing_select && !bus.io_request_n_n && io_request_n_prev_r |-> peripheral_read_strobe_n)
		else $error("Late read strobe fell in the first I/O clock.");

	chk_classic_write: assert property (@(posedge clk_sys) disable iff (reset)
		!bus.io_request_n_n && !bus.wr_n |-> !peripheral_write_strobe_n)
		else $error("Classic I/O write strobe missing.");

	chk_reg_select: assert property (@(posedge clk_sys) disable iff (reset)
		serial_reg_select == bus.addr[1:0])
		else $error("Serial register select does not follow the low address bits.");

	chk_fetch_only_wait: assert property (@(posedge clk_sys) disable iff (reset)
		mem_start && bus.io_request_n_n && bus.m1_n && fetch_marker_enable_bit
		&& ws_r == MIOAD_WS_IDLE |=> cpu_wait_n)
		else $error("Wait state inserted outside an opcode fetch.");

	chk_ack_marker: assert property (@(posedge clk_sys) disable iff (reset)
		!fetch_marker_enable_bit && !bus.m1_n && !bus.io_request_n_n |-> !fetch_marker_out_n)
		else $error("Marker missing in an acknowledge cycle.");

	chk_fetch_marker: assert property (@(posedge clk_sys) disable iff (reset)
		fetch_marker_enable_bit && !bus.m1_n && !bus.memory_request_n_n |-> !fetch_marker_out_n)
		else $error("Marker missing in an opcode fetch.");

	chk_remap_shadow: assert property (@(posedge clk_sys) disable iff (reset)
		bus.io_request_n_n && !bus.addr[15] && sram_remap && user_ram_select
		|-> !ram_chip_select_n && rom_chip_select_n)
		else $error("Remapped low half does not select only the SRAM.");

	chk_rom_user_off: assert property (@(posedge clk_sys) disable iff (reset)
		!user_rom_select |-> rom_chip_select_n)
		else $error("EPROM selected while disabled by the user.");

	chk_ram_user_off: assert property (@(posedge clk_sys) disable iff (reset)
		!user_ram_select |-> ram_chip_select_n)
		else $error("SRAM selected while disabled by the user.");

	chk_wait_bounded: assert property (@(posedge clk_sys) disable iff (reset)
		!cpu_wait_n |-> ##[1:3] cpu_wait_n)
		else $error("Wait request held longer than any wait count.");

	cov_rom_slow: cover property (@(posedge clk_sys) disable iff (reset)
		chk_rom_start && eprom_access_ns == 9'h0C8);
	cov_ram_fast: cover property (@(posedge clk_sys) disable iff (reset)
		chk_ram_start && sram_access_ns <= 9'h055);
	cov_serial_read: cover property (@(posedge clk_sys) disable iff (reset)
		serial_ctrl_chip_enable && !peripheral_read_strobe_n);
	cov_int_ack: cover property (@(posedge clk_sys) disable iff (reset)
		!fetch_marker_enable_bit && !fetch_marker_out_n);
	cov_io_late: cover property (@(posedge clk_sys) disable iff (reset)
		io_cycle_timing_select && !peripheral_read_strobe_n);

endmodule // mioad_decoder

`default_nettype wire

// File: verif/mioad_cpu_model.sv
// Purpose: Behavioural CPU bus master that drives the decoder's bus struct.
// Assumes: Requests change just after a rising edge; cpu_wait_n is read at the falling edge.
// Notes:   The bus cycle is held for a fixed six-cycle window, longer than any wait count.
`timescale 1ns/10ps
`default_nettype none

module mioad_cpu_model
	import mioad_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       cpu_wait_n,
	output var  mioad_bus_t bus
);
	initial begin
		bus = {16'h0000, 5'h1F};
	end

	task automatic put(input mioad_bus_t b);
		@(posedge clk_sys);
		bus <= b;
	endtask

	// A released bus must not keep the last address, so the lines show its inverse.
	task automatic release_bus();
		@(posedge clk_sys);
		bus <= {~bus.addr, 5'h1F};
	endtask

	// A real CPU stretches the cycle while waits are asked; the fixed window covers that.
	task automatic cycle(input mioad_bus_t b, output logic [2:0] n);
		n = 3'h0;
		put(b);
		repeat (6) begin
			@(negedge clk_sys);
			if (cpu_wait_n === 1'b0) n = n + 3'h1;
		end
		release_bus();
	endtask
endmodule // mioad_cpu_model

`default_nettype wire

// File: verif/testbench.sv
// Purpose: Self-checking bench for the memory and I/O address decoder.
// Assumes: 25 MHz clk_sys; inputs change by non-blocking assignment at the rising edge.
// Notes:   Outputs are compared at the falling edge, where they have settled.
`timescale 1ns/10ps
`default_nettype none

module testbench;
	import mioad_pkg::*;

	typedef struct packed {
		mioad_bus_t  b;
		logic [4:0]  ctl;
		logic [9:0]  exp;
	} mioad_row_t;

	logic        clk_sys;
	logic        reset;
	mioad_bus_t  bus;
	logic [4:0]  ctl;
	logic        io_cycle_timing_select;
	logic [8:0]  eprom_access_ns;
	logic [8:0]  sram_access_ns;
	logic [9:0]  seen;
	logic        rom_cs_n, ram_cs_n, oe_n, we_n, prd_n, pwr_n, sce, mk_n, wait_n;
	logic [1:0]  sel;
	logic [2:0]  n;
	int          errors;
	int          check_count;
	mioad_row_t  rows [13];

	assign seen = {rom_cs_n, ram_cs_n, oe_n, we_n, prd_n, pwr_n, sce, sel, mk_n};

	mioad_cpu_model i_mioad_cpu_model (.clk_sys(clk_sys), .cpu_wait_n(wait_n), .bus(bus));

	mioad_decoder #(.IO_WAITS(2'h2)) i_mioad_decoder (
		.clk_sys(clk_sys), .reset(reset), .bus(bus),
		.user_ram_select(ctl[4]), .user_rom_select(ctl[3]), .user_io_enable(ctl[2]),
		.sram_remap(ctl[1]), .fetch_marker_enable_bit(ctl[0]),
		.io_cycle_timing_select(io_cycle_timing_select),
		.eprom_access_ns(eprom_access_ns), .sram_access_ns(sram_access_ns),
		.rom_chip_select_n(rom_cs_n), .ram_chip_select_n(ram_cs_n),
		.mem_output_enable_n(oe_n), .sram_write_enable_n(we_n),
		.peripheral_read_strobe_n(prd_n), .peripheral_write_strobe_n(pwr_n),
		.serial_ctrl_chip_enable(sce), .serial_reg_select(sel),
		.fetch_marker_out_n(mk_n), .cpu_wait_n(wait_n));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		if (errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Sets speed and mode, runs one bus cycle and compares the wait count.
	task automatic wt(input logic [8:0] rns, input logic [8:0] sns, input logic [4:0] c,
			input mioad_bus_t b, input logic [9:0] exp);
		@(posedge clk_sys);
		eprom_access_ns <= rns;
		sram_access_ns <= sns;
		ctl <= c;
		i_mioad_cpu_model.cycle(b, n);
		check(10'(n), exp);
	endtask

	initial begin
		errors = 0;
		check_count = 0;
		reset = 1'b1;
		ctl = 5'h1D;
		io_cycle_timing_select = 1'b0;
		eprom_access_ns = 9'h0AA;
		sram_access_ns = 9'h055;
		rows = '{
			{16'h0000, 5'h0A, 5'h1D, 10'h170}, {16'h7FFF, 5'h0B, 5'h1D, 10'h17F},
			{16'h8000, 5'h0D, 5'h1D, 10'h2B1}, {16'h8001, 5'h0B, 5'h0D, 10'h373},
			{16'h0010, 5'h0B, 5'h15, 10'h371}, {16'h0123, 5'h0B, 5'h1F, 10'h277},
			{16'h00C1, 5'h13, 5'h1D, 10'h35B}, {16'h12FE, 5'h15, 5'h1D, 10'h3AD},
			{16'h003F, 5'h13, 5'h1D, 10'h357}, {16'h00C2, 5'h13, 5'h19, 10'h355},
			{16'h0000, 5'h16, 5'h1C, 10'h3F0}, {16'h0000, 5'h0A, 5'h1C, 10'h171},
			{16'h0080, 5'h13, 5'h1D, 10'h351}};
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		foreach (rows[i]) begin
			i_mioad_cpu_model.put(rows[i].b);
			ctl <= rows[i].ctl;
			@(negedge clk_sys);
			check(seen, rows[i].exp);
		end
		i_mioad_cpu_model.release_bus();
		wt(9'h0AA, 9'h055, 5'h1D, {16'h0000, 5'h0A}, 10'h001);
		wt(9'h0C8, 9'h055, 5'h1D, {16'h0000, 5'h0A}, 10'h002);
		wt(9'h0FA, 9'h055, 5'h1D, {16'h0000, 5'h0A}, 10'h002);
		wt(9'h0AA, 9'h096, 5'h1D, {16'h8000, 5'h0A}, 10'h001);
		wt(9'h0AA, 9'h055, 5'h1D, {16'h8000, 5'h0A}, 10'h000);
		wt(9'h0AA, 9'h056, 5'h1D, {16'h8000, 5'h0A}, 10'h001);
		wt(9'h0C8, 9'h055, 5'h1D, {16'h0000, 5'h0B}, 10'h000);
		wt(9'h0C8, 9'h055, 5'h1C, {16'h0000, 5'h0B}, 10'h002);
		wt(9'h0C8, 9'h055, 5'h1F, {16'h0000, 5'h0A}, 10'h000);
		wt(9'h0C8, 9'h055, 5'h1D, {16'h00C0, 5'h13}, 10'h002);
		@(posedge clk_sys);
		io_cycle_timing_select <= 1'b1;
		i_mioad_cpu_model.put({16'h00C1, 5'h13});
		@(negedge clk_sys);
		check({9'h000, prd_n}, 10'h001);
		@(negedge clk_sys);
		check({9'h000, prd_n}, 10'h000);
		i_mioad_cpu_model.release_bus();
		@(posedge clk_sys);
		io_cycle_timing_select <= 1'b0;
		eprom_access_ns <= 9'h0C8;
		i_mioad_cpu_model.put({16'h0000, 5'h0A});
		@(negedge clk_sys);
		@(negedge clk_sys);
		check({9'h000, wait_n}, 10'h000);
		@(posedge clk_sys);
		reset <= 1'b1;
		@(negedge clk_sys);
		check({9'h000, wait_n}, 10'h001);
		@(posedge clk_sys);
		reset <= 1'b0;
		i_mioad_cpu_model.release_bus();
		stop_test();
	end
endmodule // testbench

`default_nettype wire
